// ==== src/cmi_flag_group.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmi_flag_group #(
  parameter logic [7:0] IMPL = 8'hff
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  cmi_group_if.grp  g
);
  import cmi_pkg::*;

  logic [DATA_W-1:0] live_reg;
  logic [DATA_W-1:0] live_next;
  logic [DATA_W-1:0] flag_reg;
  logic [DATA_W-1:0] flag_next;
  logic [DATA_W-1:0] rise;
  logic [DATA_W-1:0] fall;
  logic [DATA_W-1:0] hit;

  // edge select per bit, then write-zero-to-clear with set winning
  always_comb begin
    live_next = g.live & IMPL;
    rise      = live_next & ~live_reg;
    fall      = ~live_next & live_reg;
    hit       = ((rise & g.pol) | (fall & ~g.pol)) & IMPL;
    flag_next = flag_reg;
    if (g.clr_we) begin
      flag_next = flag_reg & g.clr_data; // zero clears, one
    end
    flag_next = flag_next | hit; // an edge in the clear cycle survives
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      live_reg <= LIVE_RESET;
      flag_reg <= FLAG_RESET;
    end else begin
      live_reg <= live_next;
      flag_reg <= flag_next;
    end
  end

  assign g.live_q  = live_reg;
  assign g.flags   = flag_reg;
  // a set mask bit keeps its flag off the interrupt line
  assign g.pending = |(flag_reg & ~g.mask & IMPL);
endmodule
`default_nettype wire

// ==== src/cmi_group_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// one monitor group: live inputs, software controls, flag results
interface cmi_group_if;
  import cmi_pkg::*;
  logic [DATA_W-1:0] live;
  logic [DATA_W-1:0] pol;
  logic [DATA_W-1:0] mask;
  logic              clr_we;
  logic [DATA_W-1:0] clr_data;
  logic [DATA_W-1:0] live_q;
  logic [DATA_W-1:0] flags;
  logic              pending;
  modport ctrl (output live, pol, mask, clr_we, clr_data,
                input live_q, flags, pending);
  modport grp  (input live, pol, mask, clr_we, clr_data,
                output live_q, flags, pending);
endinterface
`default_nettype wire

// ==== src/cmi_pkg.sv ====
package cmi_pkg;
  // register map, one byte per address
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_SRC_LIVE    = 8'h0d;
  localparam logic [ADDR_W-1:0] OFS_DPLL_A_LIVE = 8'h0e;
  localparam logic [ADDR_W-1:0] OFS_DPLL_B_LIVE = 8'h0f;
  localparam logic [ADDR_W-1:0] OFS_SRC_MASK    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DPLL_A_MASK = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_DPLL_B_MASK = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_SRC_POL     = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_DPLL_A_POL  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DPLL_B_POL  = 8'h15;
  localparam logic [ADDR_W-1:0] OFS_SRC_FLAG    = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_DPLL_A_FLAG = 8'h17;
  localparam logic [ADDR_W-1:0] OFS_DPLL_B_FLAG = 8'h18;
  // source group implements bits 5..0; 7..6 reserved, read zero
  localparam logic [DATA_W-1:0] SRC_BITS_MASK   = 8'h3f;
  localparam logic [DATA_W-1:0] DPLL_BITS_MASK  = 8'hff;
  // field positions, dpll groups
  localparam int unsigned BIT_PHASE_LOCK_LOST   = 7;
  localparam int unsigned BIT_FREQ_LOCK_LOST    = 6;
  localparam int unsigned BIT_TUNING_HISTORY    = 5;
  localparam int unsigned BIT_HOLDOVER_EVENT    = 4;
  localparam int unsigned BIT_REFERENCE_SWITCH  = 3;
  localparam int unsigned BIT_MISSING_REF_CLOCK = 2;
  localparam int unsigned BIT_REF_FREQ_LOSS     = 1;
  localparam int unsigned BIT_REF_AMP_LOSS      = 0;
  // field positions, source group
  localparam int unsigned BIT_TCXO_FREQ_DETECT  = 5;
  localparam int unsigned BIT_XO_FREQ_DETECT    = 4;
  localparam int unsigned BIT_APLL_B_LOCK_LOSS  = 3;
  localparam int unsigned BIT_APLL_A_LOCK_LOSS  = 2;
  localparam int unsigned BIT_TCXO_SOURCE_LOSS  = 1;
  localparam int unsigned BIT_XO_SOURCE_LOSS    = 0;
  // reset values; mask and polarity have none documented, zero chosen
  localparam logic [DATA_W-1:0] LIVE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] POL_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE  = 8'h00;
endpackage

// ==== src/cmi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmi_top (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  input  wire logic [cmi_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [cmi_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [cmi_pkg::DATA_W-1:0] reg_rdata_o,
  output logic                            reg_ack_o,
  input  wire logic                       tcxo_freq_detect_loss_i,
  input  wire logic                       crystal_freq_detect_loss_i,
  input  wire logic                       analog_pll_b_lock_loss_i,
  input  wire logic                       analog_pll_a_lock_loss_i,
  input  wire logic                       tcxo_source_loss_i,
  input  wire logic                       crystal_source_loss_i,
  input  wire logic [cmi_pkg::DATA_W-1:0] dpll_a_status_i,
  input  wire logic [cmi_pkg::DATA_W-1:0] dpll_b_status_i,
  output logic                            irq_o
);
  import cmi_pkg::*;

  cmi_group_if src_g ();
  cmi_group_if dpa_g ();
  cmi_group_if dpb_g ();

  logic [DATA_W-1:0] src_mask_reg;
  logic [DATA_W-1:0] src_mask_next;
  logic [DATA_W-1:0] dpa_mask_reg;
  logic [DATA_W-1:0] dpa_mask_next;
  logic [DATA_W-1:0] dpb_mask_reg;
  logic [DATA_W-1:0] dpb_mask_next;
  logic [DATA_W-1:0] src_pol_reg;
  logic [DATA_W-1:0] src_pol_next;
  logic [DATA_W-1:0] dpa_pol_reg;
  logic [DATA_W-1:0] dpa_pol_next;
  logic [DATA_W-1:0] dpb_pol_reg;
  logic [DATA_W-1:0] dpb_pol_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              ack_reg;
  logic              ack_next;
  logic              irq_reg;
  logic              irq_next;
  logic [DATA_W-1:0] src_live;
  logic              src_mask_we;
  logic              dpa_mask_we;
  logic              dpb_mask_we;
  logic              src_pol_we;
  logic              dpa_pol_we;
  logic              dpb_pol_we;
  logic              src_flag_we;
  logic              dpa_flag_we;
  logic              dpb_flag_we;

  // source monitor bits gathered into the live byte layout
  always_comb begin
    src_live                        = LIVE_RESET;
    src_live[BIT_TCXO_FREQ_DETECT]  = tcxo_freq_detect_loss_i;
    src_live[BIT_XO_FREQ_DETECT]    = crystal_freq_detect_loss_i;
    src_live[BIT_APLL_B_LOCK_LOSS]  = analog_pll_b_lock_loss_i;
    src_live[BIT_APLL_A_LOCK_LOSS]  = analog_pll_a_lock_loss_i;
    src_live[BIT_TCXO_SOURCE_LOSS]  = tcxo_source_loss_i;
    src_live[BIT_XO_SOURCE_LOSS]    = crystal_source_loss_i;
  end

  // one write strobe per register; live and unmapped writes fall away
  assign src_mask_we = reg_we_i && (reg_addr_i == OFS_SRC_MASK);
  assign dpa_mask_we = reg_we_i && (reg_addr_i == OFS_DPLL_A_MASK);
  assign dpb_mask_we = reg_we_i && (reg_addr_i == OFS_DPLL_B_MASK);
  assign src_pol_we  = reg_we_i && (reg_addr_i == OFS_SRC_POL);
  assign dpa_pol_we  = reg_we_i && (reg_addr_i == OFS_DPLL_A_POL);
  assign dpb_pol_we  = reg_we_i && (reg_addr_i == OFS_DPLL_B_POL);
  assign src_flag_we = reg_we_i && (reg_addr_i == OFS_SRC_FLAG);
  assign dpa_flag_we = reg_we_i && (reg_addr_i == OFS_DPLL_A_FLAG);
  assign dpb_flag_we = reg_we_i && (reg_addr_i == OFS_DPLL_B_FLAG);

  // source group wiring; bits 7..6 have no monitor behind them
  assign src_g.live     = src_live;
  assign src_g.pol      = src_pol_reg;
  assign src_g.mask     = src_mask_reg;
  assign src_g.clr_we   = src_flag_we;
  assign src_g.clr_data = reg_wdata_i;

  // dpll a group wiring, full byte
  assign dpa_g.live     = dpll_a_status_i;
  assign dpa_g.pol      = dpa_pol_reg;
  assign dpa_g.mask     = dpa_mask_reg;
  assign dpa_g.clr_we   = dpa_flag_we;
  assign dpa_g.clr_data = reg_wdata_i;

  // dpll b group wiring, full byte
  assign dpb_g.live     = dpll_b_status_i;
  assign dpb_g.pol      = dpb_pol_reg;
  assign dpb_g.mask     = dpb_mask_reg;
  assign dpb_g.clr_we   = dpb_flag_we;
  assign dpb_g.clr_data = reg_wdata_i;

  cmi_flag_group #(.IMPL(SRC_BITS_MASK)) u_src (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .g         (src_g)
  );

  cmi_flag_group #(.IMPL(DPLL_BITS_MASK)) u_dpa (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .g         (dpa_g)
  );

  cmi_flag_group #(.IMPL(DPLL_BITS_MASK)) u_dpb (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .g         (dpb_g)
  );

  // source mask; reserved bits 7..6 are never stored
  always_comb begin
    src_mask_next = src_mask_reg;
    if (src_mask_we) begin
      src_mask_next = reg_wdata_i & SRC_BITS_MASK;
    end
  end

  // zero reset is a choice; software still must program it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      src_mask_reg <= MASK_RESET;
    end else begin
      src_mask_reg <= src_mask_next;
    end
  end

  // dpll a mask, same layout as its live byte
  always_comb begin
    dpa_mask_next = dpa_mask_reg;
    if (dpa_mask_we) begin
      dpa_mask_next = reg_wdata_i;
    end
  end

  // dpll a mask register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dpa_mask_reg <= MASK_RESET;
    end else begin
      dpa_mask_reg <= dpa_mask_next;
    end
  end

  // dpll b mask, same layout as its live byte
  always_comb begin
    dpb_mask_next = dpb_mask_reg;
    if (dpb_mask_we) begin
      dpb_mask_next = reg_wdata_i;
    end
  end

  // dpll b mask register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dpb_mask_reg <= MASK_RESET;
    end else begin
      dpb_mask_reg <= dpb_mask_next;
    end
  end

  // source polarity; bits 5..0 kept writable to match the layout
  always_comb begin
    src_pol_next = src_pol_reg;
    if (src_pol_we) begin
      src_pol_next = reg_wdata_i & SRC_BITS_MASK;
    end
  end

  // zero selects falling edges until software says otherwise
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      src_pol_reg <= POL_RESET;
    end else begin
      src_pol_reg <= src_pol_next;
    end
  end

  // dpll a polarity, one edge select per live bit
  always_comb begin
    dpa_pol_next = dpa_pol_reg;
    if (dpa_pol_we) begin
      dpa_pol_next = reg_wdata_i;
    end
  end

  // dpll a polarity register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dpa_pol_reg <= POL_RESET;
    end else begin
      dpa_pol_reg <= dpa_pol_next;
    end
  end

  // dpll b polarity, one edge select per live bit
  always_comb begin
    dpb_pol_next = dpb_pol_reg;
    if (dpb_pol_we) begin
      dpb_pol_next = reg_wdata_i;
    end
  end

  // dpll b polarity register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dpb_pol_reg <= POL_RESET;
    end else begin
      dpb_pol_reg <= dpb_pol_next;
    end
  end

  // read mux; live bytes are the registered monitor samples
  always_comb begin
    rdata_next = READ_IDLE;
    if (reg_re_i) begin
      case (reg_addr_i)
        OFS_SRC_LIVE: begin
          rdata_next = src_g.live_q;
        end
        OFS_DPLL_A_LIVE: begin
          rdata_next = dpa_g.live_q;
        end
        OFS_DPLL_B_LIVE: begin
          rdata_next = dpb_g.live_q;
        end
        OFS_SRC_MASK: begin
          rdata_next = src_mask_reg;
        end
        OFS_DPLL_A_MASK: begin
          rdata_next = dpa_mask_reg;
        end
        OFS_DPLL_B_MASK: begin
          rdata_next = dpb_mask_reg;
        end
        OFS_SRC_POL: begin
          rdata_next = src_pol_reg;
        end
        OFS_DPLL_A_POL: begin
          rdata_next = dpa_pol_reg;
        end
        OFS_DPLL_B_POL: begin
          rdata_next = dpb_pol_reg;
        end
        OFS_SRC_FLAG: begin
          rdata_next = src_g.flags;
        end
        OFS_DPLL_A_FLAG: begin
          rdata_next = dpa_g.flags;
        end
        OFS_DPLL_B_FLAG: begin
          rdata_next = dpb_g.flags;
        end
        default: begin
          rdata_next = READ_IDLE; // unmapped reads zero
        end
      endcase
    end
  end

  // read data stands one cycle, then returns to idle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // every strobe is answered, mapped or not, so no master hangs
  always_comb begin
    ack_next = reg_re_i | reg_we_i;
  end

  // acknowledge pulse register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // interrupt registered to keep the pin glitch free
  always_comb begin
    irq_next = src_g.pending | dpa_g.pending | dpb_g.pending;
  end

  // interrupt level register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_ack_o   = ack_reg;
  assign irq_o       = irq_reg;
endmodule
`default_nettype wire

// ==== verif/cmi_top_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmi_top_props
  import cmi_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  input wire logic              reg_we_i,
  input wire logic              reg_re_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              reg_ack_o,
  input wire logic [DATA_W-1:0] dpll_a_status_i,
  input wire logic [DATA_W-1:0] dpll_b_status_i,
  input wire logic              irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [DATA_W-1:0] shd_reg[3];
  logic [DATA_W-1:0] shd_next[3];
  logic              all_masked;
  // mirror of mask writes, since masks are only reachable by the bus
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      shd_next[g] = shd_reg[g];
      if (reg_we_i && reg_addr_i == OFS_SRC_MASK + 8'(g)) begin
        shd_next[g] = reg_wdata_i;
      end
    end
    if (!rst_n_i) begin
      shd_next = '{default: MASK_RESET};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    shd_reg <= shd_next;
  end
  assign all_masked = &{shd_reg[0][5:0], shd_reg[1], shd_reg[2]};
  // bus handshake, read path and interrupt masking
  ack_after_req_a: assert property ((reg_we_i || reg_re_i) |=> reg_ack_o)
    else $error("ack missing after request");
  ack_has_cause_a: assert property (reg_ack_o |-> $past(reg_we_i || reg_re_i))
    else $error("ack without request");
  idle_rdata_a: assert property (!reg_re_i |=> reg_rdata_o == READ_IDLE)
    else $error("read data not idle");
  live_b_lag_a: assert property (
    (reg_re_i && reg_addr_i == OFS_DPLL_B_LIVE)
    |=> reg_rdata_o == $past(dpll_b_status_i, 2)) else $error("live b bad");
  live_a_lag_a: assert property (
    (reg_re_i && reg_addr_i == OFS_DPLL_A_LIVE)
    |=> reg_rdata_o == $past(dpll_a_status_i, 2)) else $error("live a bad");
  src_reserved_a: assert property (
    reg_re_i && (reg_addr_i == OFS_SRC_MASK
    || reg_addr_i == OFS_SRC_POL) |=> reg_rdata_o[7:6] == 2'b00)
    else $error("reserved bits not zero");
  mask_a_back_a: assert property (
    (reg_re_i && reg_addr_i == OFS_DPLL_A_MASK)
    |=> reg_rdata_o == $past(shd_reg[1])) else $error("mask a readback");
  mask_b_back_a: assert property (
    (reg_re_i && reg_addr_i == OFS_DPLL_B_MASK)
    |=> reg_rdata_o == $past(shd_reg[2])) else $error("mask b readback");
  all_masked_a: assert property (all_masked |=> !irq_o)
    else $error("irq while all masked");
  unmapped_a: assert property (reg_re_i && (reg_addr_i < OFS_SRC_LIVE
    || reg_addr_i > OFS_DPLL_B_FLAG) |=> reg_rdata_o == READ_IDLE)
    else $error("unmapped read not zero");
  cover property ($rose(irq_o));
  cover property (all_masked ##1 1'b1);
  cover property (reg_we_i && reg_addr_i == OFS_DPLL_A_FLAG);
endmodule
bind cmi_top cmi_top_props u_props (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .irq_o(irq_o),
  .dpll_a_status_i(dpll_a_status_i), .dpll_b_status_i(dpll_b_status_i));
`default_nettype wire

// ==== verif/cmi_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmi_top_tb;
  import cmi_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              reg_we_i = 1'b0;
  logic              reg_re_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              reg_ack_o;
  logic              irq_o;
  logic [DATA_W-1:0] lv[3] = '{default: '0};
  int                n_errors = 0;
  int                comparisons = 0;
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  cmi_top u_cmi_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .tcxo_freq_detect_loss_i(lv[0][5]),
    .crystal_freq_detect_loss_i(lv[0][4]),
    .analog_pll_b_lock_loss_i(lv[0][3]),
    .analog_pll_a_lock_loss_i(lv[0][2]), .tcxo_source_loss_i(lv[0][1]),
    .crystal_source_loss_i(lv[0][0]), .dpll_a_status_i(lv[1]),
    .dpll_b_status_i(lv[2]), .irq_o(irq_o));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes move at the falling edge, away from the sampling edge
  task automatic acc(logic we, logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk_i);
    reg_we_i = we;
    reg_re_i = !we;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    check("ack", 8'h01, {7'h00, reg_ack_o});
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check("rdata", exp, reg_rdata_o);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] p, v0, v1, w, e, im;
    void'($urandom(32'h8e85ea62));
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    // whole map plus unmapped neighbours read zero after reset
    for (int a = 0; a < 8'h1a; a++) begin
      rd(8'(a), 8'h00);
    end
    for (int g = 0; g < 3; g++) begin
      acc(1'b1, OFS_SRC_MASK + 8'(g), 8'hff);
      lv[g] = 8'hff;
    end
    repeat (3) @(negedge sys_clk_i);
    check("irq", 8'h00, {7'h00, irq_o});
    // k 0 and 1 are all-rising and all-falling corners
    for (int g = 0; g < 3; g++) begin
      im = (g == 0) ? SRC_BITS_MASK : DPLL_BITS_MASK;
      for (int k = 0; k < 4; k++) begin
        p = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
        v0 = (k < 2) ? ~p : 8'($urandom);
        v1 = (k < 2) ? p : 8'($urandom);
        w = 8'($urandom);
        e = im & ((p & ~v0 & v1) | (~p & v0 & ~v1));
        acc(1'b1, OFS_SRC_MASK + 8'(g), w);
        rd(OFS_SRC_MASK + 8'(g), w & im);
        acc(1'b1, OFS_SRC_POL + 8'(g), p);
        rd(OFS_SRC_POL + 8'(g), p & im);
        acc(1'b1, OFS_SRC_MASK + 8'(g), 8'hff);
        lv[g] = v0;
        acc(1'b1, OFS_SRC_LIVE + 8'(g), ~v0);
        rd(OFS_SRC_LIVE + 8'(g), v0 & im);
        // odd k: the live edge meets the clearing write, set must win
        @(negedge sys_clk_i);
        reg_we_i = 1'b1;
        reg_addr_i = OFS_SRC_FLAG + 8'(g);
        reg_wdata_i = 8'h00;
        if (k[0]) begin
          lv[g] = v1;
        end
        @(negedge sys_clk_i);
        reg_we_i = 1'b0;
        check("ack", 8'h01, {7'h00, reg_ack_o});
        lv[g] = v1;
        rd(OFS_SRC_FLAG + 8'(g), e);
        check("irq", 8'h00, {7'h00, irq_o});
        acc(1'b1, OFS_SRC_MASK + 8'(g), w);
        repeat (2) @(negedge sys_clk_i);
        check("irq", {7'h00, |(e & ~w)}, {7'h00, irq_o});
        v0 = 8'($urandom);
        acc(1'b1, OFS_SRC_FLAG + 8'(g), v0);
        rd(OFS_SRC_FLAG + 8'(g), e & v0);
        acc(1'b1, OFS_SRC_FLAG + 8'(g), 8'h00);
        repeat (2) @(negedge sys_clk_i);
        check("irq", 8'h00, {7'h00, irq_o});
      end
    end
    // reset again mid-run: registers clear, live inputs stay up
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    for (int a = OFS_SRC_MASK; a <= OFS_DPLL_B_FLAG; a++) begin
      rd(8'(a), 8'h00);
    end
    rd(OFS_DPLL_A_LIVE, lv[1]);
    rd(OFS_DPLL_B_LIVE, lv[2]);
    check("irq", 8'h00, {7'h00, irq_o});
    print_verdict();
  end
endmodule
`default_nettype wire
